// [hdl/dcs_pkg.sv]
// Constants, register map and decode helpers for the dynamic clock source switch
package dcs_pkg;
  // ==========================================================
  // Register map (byte addresses) and fields
  localparam logic [3:0] A_SEL  = 4'h0;
  localparam logic [3:0] A_CMD  = 4'h4;
  localparam logic [3:0] A_STAT = 4'h8;
  localparam int F_SUT  = 4;
  localparam int F_CLOCK_OUTPUT_BIT = 6;
  localparam int F_CCE  = 7;
  localparam int F_RDY  = 4;
  localparam int F_BUSY = 5;
  localparam int F_WDAR = 6;
  localparam logic [7:0] CCE_WORD = 8'h80;
  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_DIS  = 8'h01;
  localparam logic [7:0] CMD_EN   = 8'h02;
  localparam logic [7:0] CMD_REQ  = 8'h03;
  localparam logic [7:0] CMD_SW   = 8'h04;
  localparam logic [7:0] CMD_REC  = 8'h05;
  localparam logic [7:0] CMD_WDAR = 8'h06;
  // ==========================================================
  // Sources: index into enable vector, and select codes
  localparam int NSRC   = 5;
  localparam int S_RC   = 0;
  localparam int S_WDT  = 1;
  localparam int S_EXT  = 2;
  localparam int S_LF   = 3;
  localparam int S_XT   = 4;
  localparam logic [3:0] CODE_EXT = 4'h0;
  localparam logic [3:0] CODE_RC  = 4'h2;
  localparam logic [3:0] CODE_WDT = 4'h3;
  localparam logic [1:0] CODE_LF  = 2'h1;
  // ==========================================================
  // Start-up and reset counts
  localparam logic [15:0] N_6    = 16'h0006;
  localparam logic [15:0] N_14   = 16'h000e;
  localparam logic [15:0] N_258  = 16'h0102;
  localparam logic [15:0] N_1K   = 16'h0400;
  localparam logic [15:0] N_16K  = 16'h4000;
  localparam logic [15:0] N_32K  = 16'h8000;
  localparam logic [2:0]  GATE_N = 3'h4;
  localparam int CLK_MHZ    = 200;
  localparam int T_SHORT_US = 4100;   // 4.1 ms
  localparam int T_LONG_US  = 65000;  // 65 ms
  localparam int SHORT_CYC  = T_SHORT_US * CLK_MHZ;
  localparam int LONG_CYC   = T_LONG_US * CLK_MHZ;

  // Map a select code to its source index
  function automatic int src_of(input logic [3:0] c);
    if (c[3])
      return S_XT;
    if (c[3:2] == CODE_LF)
      return S_LF;
    if (c == CODE_EXT)
      return S_EXT;
    if (c == CODE_WDT)
      return S_WDT;
    return S_RC;
  endfunction
endpackage

// [hdl/dcs_switch.sv]
// Dynamic clock source switch with protected command register on Avalon-MM
`timescale 1ns/100ps
// What this block does
// - Low-freq crystal: 1024 or 32768 start cycles, 4.1ms or 65ms reset delay.
// - External clock: 6 start cycles (32768 with code 11), reset 14 cycles plus 4.1ms or 65ms.
// - External clock code 00 adds 4.1ms only with reset pin disabled.
// - Timer may start low-freq crystal if crystal off or external off.
// - Timer may enable external clock when neither crystal runs.
// - Clock output set and no crystal used drives system clock on pin.
// - Clock output pin never carries the clock during reset.
// - Clock output carries the prescaled system clock.
// - Command register changes only through the protected write.
// - Protected write: change-enable alone, then command code next.
// - Each command write is one exclusive action, one at a time.
// - Six actions: disable, enable, request, switch, recover, watchdog reload.
// - Codes: disable 01, enable 02, switch 04, recover 05, watchdog 06.
// - Reset loads select register from fuses, clock-output bit inverted.
// - Enable turns source on and starts the readiness count.
// - Disable turns source off unless it drives the system clock.
// - Several sources may stay enabled together.
// - Request counts source edges to limit; ready cleared at start.
// - Recover writes current source code into select field only.
// - Switch moves the system clock to the selected source.
// - Source enables and clock switching are deglitched.
module dcs_switch
  import dcs_pkg::*;
#(
  parameter int SHORT_N = SHORT_CYC,
  parameter int LONG_N  = LONG_CYC
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Avalon-MM slave
  input  wire logic [3:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [3:0]       avs_byteenable,
  input  wire logic [31:0]      avs_writedata,
  output logic      [31:0]      avs_readdata,
  output logic                  avs_waitrequest,
  // Fuses
  input  wire logic [7:0]       fuse_low,
  input  wire logic             reset_pin_disable_fuse,
  // Source clocks and asynchronous timer
  input  wire logic [NSRC-1:0]  src_clk_pins,
  input  wire logic             atimer_lf_req,
  input  wire logic             atimer_ext_req,
  output logic      [NSRC-1:0]  osc_enable,
  // System clock mux control
  output logic      [2:0]       sys_src_idx,
  output logic                  sys_clk_gate,
  output logic                  core_rst_hold,
  output logic                  wdog_auto_reload,
  // Clock output pin
  input  wire logic             sys_clk_div,
  input  wire logic             pin_io_out,
  input  wire logic             pin_io_oe,
  output logic                  clock_output_pin_out,
  output logic                  clock_output_pin_oe
);

  // ==========================================================
  // Declarations
  typedef enum logic [1:0] {SW_IDLE, SW_GATE, SW_OPEN} dcs_sw_t;
  typedef enum logic [1:0] {RD_CK, RD_MS, RD_DONE} dcs_rd_t;
  logic [6:0]       sel_reg;
  logic             armed_reg;
  logic             ready_reg;
  logic             run_reg;
  logic [15:0]      cnt_reg;
  logic [15:0]      lim_reg;
  logic [2:0]       csrc_reg;
  logic [NSRC-1:0]  en_reg;
  logic [3:0]       cur_code_reg;
  logic             wdar_reg;
  logic             ack_reg;
  logic [31:0]      rdata_reg;
  dcs_sw_t          sw_reg;
  logic [2:0]       gate_cnt_reg;
  logic [2:0]       tgt_reg;
  logic [3:0]       tgt_code_reg;
  dcs_rd_t          rd_reg;
  logic [31:0]      rd_cnt_reg;
  logic [31:0]      rd_lim_reg;
  logic [NSRC-1:0]  s1_reg, s2_reg, s3_reg, lvl_reg, edge_reg;
  logic [2:0]       dv_reg;
  logic             do_wr, do_cmd, cmd_ok;
  logic [7:0]       wbyte;
  logic [2:0]       sel_src;
  logic [15:0]      lim_next;

  // ==========================================================
  // Source clock sampling: three flops, level taken when 2nd and 3rd agree
  for (genvar i = 0; i < NSRC; i++) begin : g_smp
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        s1_reg[i]   <= 1'b0;
        s2_reg[i]   <= 1'b0;
        s3_reg[i]   <= 1'b0;
        lvl_reg[i]  <= 1'b0;
        edge_reg[i] <= 1'b0;
      end else begin
        s1_reg[i]   <= src_clk_pins[i];
        s2_reg[i]   <= s1_reg[i];
        s3_reg[i]   <= s2_reg[i];
        if (s2_reg[i] == s3_reg[i])
          lvl_reg[i] <= s3_reg[i];
        edge_reg[i] <= (s2_reg[i] == s3_reg[i]) & s3_reg[i] & ~lvl_reg[i];
      end
    end
  end

  // ==========================================================
  // Avalon slave: one wait cycle, then acknowledge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign avs_readdata    = rdata_reg;
  assign do_wr  = avs_write & ack_reg & avs_byteenable[0];
  assign wbyte  = avs_writedata[7:0];
  assign do_cmd = do_wr & (avs_address == A_CMD) & armed_reg & (wbyte != CCE_WORD);
  assign cmd_ok = sw_reg == SW_IDLE;
  assign sel_src = 3'(src_of(sel_reg[3:0]));

  always_ff @(posedge core_clk) begin
    if (!rst_n)
      ack_reg <= 1'b0;
    else
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
  end

  // Read data, captured one cycle before acknowledge; unmapped reads zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read & ~ack_reg) begin
      rdata_reg <= 32'h0000_0000;
      case (avs_address)
        A_SEL:  rdata_reg[6:0] <= sel_reg;
        A_CMD: begin
          rdata_reg[F_CCE]  <= armed_reg;
          rdata_reg[F_RDY]  <= ready_reg;
          rdata_reg[F_BUSY] <= run_reg | (sw_reg != SW_IDLE);
        end
        A_STAT: begin
          rdata_reg[NSRC-1:0] <= en_reg;
          rdata_reg[11:8]     <= cur_code_reg;
          rdata_reg[15:12]    <= {1'b0, sys_src_idx};
        end
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // Protected write: change-enable alone arms, the next write launches if it goes to the command register
  always_ff @(posedge core_clk) begin
    if (!rst_n)
      armed_reg <= 1'b0;
    else if (do_wr & (avs_address == A_CMD))
      armed_reg <= (wbyte == CCE_WORD) & ~armed_reg;
    else if (do_wr)
      armed_reg <= 1'b0;
  end

  // Select register: fuse copy at reset, software write, recover update
  always_ff @(posedge core_clk) begin
    if (!rst_n)
      sel_reg <= {~fuse_low[F_CLOCK_OUTPUT_BIT], fuse_low[5:0]};
    else if (do_cmd & cmd_ok & (wbyte == CMD_REC))
      sel_reg[3:0] <= cur_code_reg;
    else if (do_wr & (avs_address == A_SEL))
      sel_reg <= wbyte[6:0];
  end

  // Readiness count limit from source kind and start-up code
  always_comb begin
    lim_next = N_32K;
    case (sel_src)
      3'(S_LF):
        lim_next = (sel_reg[5:4] == 2'h2) ? N_32K : N_1K;
      3'(S_XT):
        if (sel_reg[0])
          lim_next = (sel_reg[5:4] == 2'h0) ? N_1K : N_16K;
        else
          lim_next = sel_reg[5] ? N_1K : N_258;
      default:
        lim_next = N_6;
    endcase
    if (sel_src != 3'(S_XT) && sel_reg[5:4] == 2'h3)
      lim_next = N_32K;
  end

  // Readiness counter on the selected source's edges
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      run_reg   <= 1'b0;
      ready_reg <= 1'b0;
      cnt_reg   <= 16'h0000;
      lim_reg   <= N_32K;
      csrc_reg  <= 3'h0;
    end else if (do_cmd & cmd_ok & ((wbyte == CMD_EN) | (wbyte == CMD_REQ))) begin
      run_reg   <= 1'b1;
      ready_reg <= 1'b0;
      cnt_reg   <= 16'h0000;
      lim_reg   <= lim_next;
      csrc_reg  <= sel_src;
    end else if (run_reg & edge_reg[csrc_reg]) begin
      cnt_reg <= cnt_reg + 16'h0001;
      if (cnt_reg + 16'h0001 == lim_reg) begin
        run_reg   <= 1'b0;
        ready_reg <= 1'b1;
      end
    end
  end

  // Source enables; several may be on together
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      en_reg <= '0;
      en_reg[src_of(fuse_low[3:0])] <= 1'b1;
    end else if (do_cmd & cmd_ok & (wbyte == CMD_EN)) begin
      en_reg[sel_src] <= 1'b1;
    end else if (do_cmd & cmd_ok & (wbyte == CMD_DIS)) begin
      if (sel_src != sys_src_idx)
        en_reg[sel_src] <= 1'b0;
    end
  end

  // Registered enables with timer grants; one flop keeps them glitch free
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      osc_enable <= '0;
    end else begin
      osc_enable <= en_reg;
      if (atimer_lf_req & (~en_reg[S_XT] | ~en_reg[S_EXT]))
        osc_enable[S_LF] <= 1'b1;
      if (atimer_ext_req & ~en_reg[S_XT] & ~en_reg[S_LF])
        osc_enable[S_EXT] <= 1'b1;
    end
  end

  // Watchdog automatic reload, cleared only by reset
  always_ff @(posedge core_clk) begin
    if (!rst_n)
      wdar_reg <= 1'b0;
    else if (do_cmd & cmd_ok & (wbyte == CMD_WDAR))
      wdar_reg <= 1'b1;
  end
  assign wdog_auto_reload = wdar_reg;

  // Switch sequence: gate clock, move mux, reopen
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sw_reg       <= SW_IDLE;
      gate_cnt_reg <= 3'h0;
      tgt_reg      <= 3'(src_of(fuse_low[3:0]));
      tgt_code_reg <= fuse_low[3:0];
      sys_src_idx  <= 3'(src_of(fuse_low[3:0]));
      cur_code_reg <= fuse_low[3:0];
      sys_clk_gate <= 1'b1;
    end else begin
      case (sw_reg)
        SW_IDLE:
          if (do_cmd & (wbyte == CMD_SW) & en_reg[sel_src]) begin
            sw_reg       <= SW_GATE;
            tgt_reg      <= sel_src;
            tgt_code_reg <= sel_reg[3:0];
            gate_cnt_reg <= 3'h0;
            sys_clk_gate <= 1'b0;
          end
        SW_GATE: begin
          gate_cnt_reg <= gate_cnt_reg + 3'h1;
          if (gate_cnt_reg == GATE_N - 3'h1) begin
            sys_src_idx  <= tgt_reg;
            cur_code_reg <= tgt_code_reg;
            sw_reg       <= SW_OPEN;
          end
        end
        SW_OPEN: begin
          sys_clk_gate <= 1'b1;
          sw_reg       <= SW_IDLE;
        end
        default: sw_reg <= SW_IDLE;
      endcase
    end
  end

  // Reset extension: source cycles then a core-clock delay
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_reg     <= RD_CK;
      rd_cnt_reg <= 32'h0000_0000;
      rd_lim_reg <= 32'h0000_0000;
    end else begin
      case (rd_reg)
        RD_CK:
          if (sys_src_idx == 3'(S_LF) || rd_cnt_reg[15:0] == N_14) begin
            rd_reg     <= RD_MS;
            rd_cnt_reg <= 32'h0000_0000;
            case (sel_reg[5:4])
              2'h0: rd_lim_reg <= (sys_src_idx == 3'(S_LF) || reset_pin_disable_fuse)
                                  ? 32'(SHORT_N) : 32'h0000_0000;
              2'h1: rd_lim_reg <= (sys_src_idx == 3'(S_LF))
                                  ? 32'(LONG_N) : 32'(SHORT_N);
              default: rd_lim_reg <= 32'(LONG_N);
            endcase
          end else if (edge_reg[sys_src_idx]) begin
            rd_cnt_reg <= rd_cnt_reg + 32'h0000_0001;
          end
        RD_MS:
          if (rd_cnt_reg >= rd_lim_reg)
            rd_reg <= RD_DONE;
          else
            rd_cnt_reg <= rd_cnt_reg + 32'h0000_0001;
        RD_DONE: rd_reg <= RD_DONE;
        default: rd_reg <= RD_CK;
      endcase
    end
  end
  assign core_rst_hold = rd_reg != RD_DONE;

  // Clock output pin: divided system clock, sampled, overrides normal I/O
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dv_reg               <= 3'h0;
      clock_output_pin_out <= 1'b0;
      clock_output_pin_oe  <= 1'b0;
    end else begin
      dv_reg <= {dv_reg[1:0], sys_clk_div};
      if (sel_reg[F_CLOCK_OUTPUT_BIT] & ~osc_enable[S_XT] & ~osc_enable[S_LF] & ~core_rst_hold) begin
        if (dv_reg[1] == dv_reg[2])
          clock_output_pin_out <= dv_reg[2];
        clock_output_pin_oe <= 1'b1;
      end else begin
        clock_output_pin_out <= pin_io_out;
        clock_output_pin_oe  <= pin_io_oe & ~core_rst_hold;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_arm;
    do_wr && avs_address == A_CMD && wbyte == CCE_WORD && !armed_reg;
  endsequence
  sequence s_plain;
    do_wr && avs_address == A_CMD && !armed_reg && wbyte != CCE_WORD;
  endsequence

  chk_arm_then_cmd: assert property (s_arm |=> armed_reg)
    else $error("change enable did not arm");
  chk_unarmed_noop: assert property (s_plain |=> $stable(en_reg) && !wdar_reg || $past(wdar_reg))
    else $error("unprotected write acted");
  chk_ready_clear: assert property (do_cmd && cmd_ok && wbyte == CMD_REQ |=> !ready_reg && run_reg)
    else $error("request did not restart count");
  chk_ready_hold: assert property (ready_reg && !run_reg && !do_cmd |=> ready_reg)
    else $error("ready flag dropped");
  chk_dis_current: assert property (do_cmd && cmd_ok && wbyte == CMD_DIS && sel_src == sys_src_idx
    |=> en_reg[sys_src_idx])
    else $error("current source disabled");
  chk_en_starts: assert property (do_cmd && cmd_ok && wbyte == CMD_EN |=> en_reg[csrc_reg] && run_reg)
    else $error("enable did not start count");
  chk_recover_sel: assert property (do_cmd && cmd_ok && wbyte == CMD_REC |=> sel_reg[3:0] == cur_code_reg
    && sel_reg[6:4] == $past(sel_reg[6:4]))
    else $error("recover wrong");
  chk_switch_done: assert property ($rose(sw_reg == SW_GATE) |-> ##[4:6]
    sys_clk_gate && sys_src_idx == tgt_reg)
    else $error("switch did not complete");
  chk_gate_closed: assert property ($changed(sys_src_idx) |-> !sys_clk_gate)
    else $error("mux moved with clock open");
  chk_ext_grant: assert property (atimer_ext_req && !en_reg[S_XT] && !en_reg[S_LF]
    |=> osc_enable[S_EXT])
    else $error("timer external grant missing");
  chk_lf_grant: assert property (atimer_lf_req && !en_reg[S_XT] |=> osc_enable[S_LF])
    else $error("timer crystal grant missing");
  chk_pin_reset: assert property (core_rst_hold |=> !clock_output_pin_oe || !$past(core_rst_hold))
    else $error("clock output during reset");
endmodule

// [sim/dcs_osc_model.sv]
// Oscillator sources and prescaled system clock facing the switch
`timescale 1ns/100ps
module dcs_osc_model
  import dcs_pkg::*;
(
  // Enables from the switch
  input  wire logic [NSRC-1:0] osc_enable,
  // Source clocks and divided system clock
  output logic      [NSRC-1:0] src_clk_pins,
  output logic                 sys_clk_div
);
  // ==========================================================
  // Sources
  // Each source toggles only while enabled and stands low otherwise
  for (genvar i = 0; i < NSRC; i++) begin : g_src
    initial begin
      src_clk_pins[i] = 1'b0;
      forever begin
        #(12 + 4 * i);
        src_clk_pins[i] = osc_enable[i] ? ~src_clk_pins[i] : 1'b0;
      end
    end
  end

  // Prescaled clock runs free, slow against the core clock
  initial begin
    sys_clk_div = 1'b0;
    forever #60 sys_clk_div = ~sys_clk_div;
  end
endmodule

// [sim/dcs_switch_tb.sv]
// Self-checking bench for the dynamic clock source switch
`timescale 1ns/100ps
module dcs_switch_tb
  import dcs_pkg::*;
();
  // ==========================================================
  // Signals
  logic            core_clk      = 1'b0;
  logic            rst_n         = 1'b0;
  logic [3:0]      avs_address   = 4'h0;
  logic            avs_read      = 1'b0;
  logic            avs_write     = 1'b0;
  logic [3:0]      be            = 4'hf;
  logic [31:0]     avs_writedata = 32'h0;
  logic [31:0]     avs_readdata;
  logic [31:0]     rd;
  logic            avs_waitrequest;
  logic [7:0]      fuse          = 8'h00;
  logic            rpd           = 1'b0;
  logic            lf_req        = 1'b0;
  logic            ext_req       = 1'b0;
  logic            io_out        = 1'b0;
  logic            io_oe         = 1'b0;
  logic [NSRC-1:0] src_clk_pins;
  logic [NSRC-1:0] osc_enable;
  logic [2:0]      sys_src_idx;
  logic            sys_clk_gate;
  logic            core_rst_hold;
  logic            wdog_auto_reload;
  logic            sys_clk_div;
  logic            pin_out;
  logic            pin_oe;
  int              errors = 0;
  int              checks = 0;
  int              cnt;
  logic            div_lvl;

  // Clock at 200 MHz
  always #2.5 core_clk = ~core_clk;

  // ==========================================================
  // Instances
  dcs_switch #(.SHORT_N(40), .LONG_N(80)) dcs_switch_i (
    .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(be),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .fuse_low(fuse),
    .reset_pin_disable_fuse(rpd), .src_clk_pins(src_clk_pins),
    .atimer_lf_req(lf_req), .atimer_ext_req(ext_req), .osc_enable(osc_enable),
    .sys_src_idx(sys_src_idx), .sys_clk_gate(sys_clk_gate),
    .core_rst_hold(core_rst_hold), .wdog_auto_reload(wdog_auto_reload),
    .sys_clk_div(sys_clk_div), .pin_io_out(io_out), .pin_io_oe(io_oe),
    .clock_output_pin_out(pin_out), .clock_output_pin_oe(pin_oe));
  dcs_osc_model dcs_osc_model_i (
    .osc_enable(osc_enable), .src_clk_pins(src_clk_pins), .sys_clk_div(sys_clk_div));

  // ==========================================================
  // Tasks
  task automatic conclude();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Wait for waitrequest low at a rising edge, bounded
  task automatic wait_ack();
    int i;
    for (i = 0; i < 40; i++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 40) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, avs_waitrequest, 1'b0);
      conclude();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    avs_write     <= 1'b1;
    wait_ack();
    avs_write     <= 1'b0;
  endtask

  task automatic rdr(input logic [3:0] a);
    @(posedge core_clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    wait_ack();
    rd = avs_readdata;
    avs_read    <= 1'b0;
  endtask

  // Protected write: arm alone, then the code
  task automatic cmd(input logic [7:0] c);
    wr(A_CMD, CCE_WORD);
    wr(A_CMD, c);
  endtask

  // Poll one command-register bit for a value, bounded
  task automatic poll(input int f, input logic v);
    int i;
    for (i = 0; i < 100; i++) begin
      rdr(A_CMD);
      if (rd[f] === v) break;
    end
    check({31'h0, rd[f]}, {31'h0, v});
    if (i == 100)
      conclude();
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    int k;
    repeat (8) @(posedge core_clk);
    check({31'h0, pin_oe}, 32'h0);
    check({31'h0, core_rst_hold}, 32'h1);
    rst_n <= 1'b1;
    for (cnt = 0; cnt < 300; cnt++) begin
      @(posedge core_clk);
      if (core_rst_hold === 1'b0) break;
    end
    check(32'(cnt >= 105 && cnt <= 140), 32'h1);
    rdr(A_SEL);
    check(rd, 32'h40);
    $display("test reset done");

    // Clock output follows the divided clock, not the port function, on both levels
    @(posedge core_clk);
    io_out <= 1'b1;
    repeat (2) begin
      div_lvl = sys_clk_div;
      for (k = 0; k < 40; k++) begin
        @(posedge core_clk);
        if (sys_clk_div !== div_lvl) break;
      end
      repeat (8) @(posedge core_clk);
      check({31'h0, pin_oe}, 32'h1);
      check({31'h0, pin_out}, {31'h0, ~div_lvl});
    end
    $display("test clock output done");

    // Unprotected and disarmed writes launch nothing; lane 0 off ignores a write
    be <= 4'he;
    wr(A_SEL, 8'h00);
    be <= 4'hf;
    rdr(A_SEL);
    check(rd, 32'h40);
    wr(A_CMD, CMD_WDAR);
    wr(A_CMD, CCE_WORD);
    rdr(A_CMD);
    check({31'h0, rd[F_CCE]}, 32'h1);
    wr(A_SEL, 8'h40);
    wr(A_CMD, CMD_WDAR);
    repeat (2) @(posedge core_clk);
    check({31'h0, wdog_auto_reload}, 32'h0);
    rdr(4'hc);
    check(rd, 32'h0);
    $display("test protection done");

    // Enable RC beside EXT; select held still while counting
    wr(A_SEL, 8'h42);
    cmd(CMD_EN);
    poll(F_RDY, 1'b1);
    rdr(A_STAT);
    check({27'h0, rd[4:0]}, 32'h05);
    cmd(CMD_REQ);
    rdr(A_CMD);
    check({31'h0, rd[F_RDY]}, 32'h0);
    poll(F_RDY, 1'b1);
    $display("test enable done");

    // Switch to the ready source, confirm, then retire the old one
    cmd(CMD_SW);
    @(posedge core_clk);
    check({31'h0, sys_clk_gate}, 32'h0);
    poll(F_BUSY, 1'b0);
    check({29'h0, sys_src_idx}, 32'(S_RC));
    check({31'h0, sys_clk_gate}, 32'h1);
    wr(A_SEL, 8'h73);
    cmd(CMD_REC);
    rdr(A_SEL);
    check(rd, 32'h72);
    wr(A_SEL, 8'h42);
    cmd(CMD_DIS);
    repeat (4) @(posedge core_clk);
    check({31'h0, osc_enable[S_RC]}, 32'h1);
    wr(A_SEL, 8'h40);
    cmd(CMD_DIS);
    repeat (4) @(posedge core_clk);
    check({31'h0, osc_enable[S_EXT]}, 32'h0);
    cmd(CMD_WDAR);
    repeat (4) @(posedge core_clk);
    check({31'h0, wdog_auto_reload}, 32'h1);
    $display("test switch done");

    // Timer starts the low-frequency crystal; clock output then yields
    @(posedge core_clk);
    lf_req <= 1'b1;
    repeat (8) @(posedge core_clk);
    check({31'h0, osc_enable[S_LF]}, 32'h1);
    check({31'h0, pin_oe}, 32'h0);
    check({31'h0, pin_out}, {31'h0, io_out});
    $display("test timer done");

    // Timer enables the external input; then reset again with reset pin disabled
    ext_req <= 1'b1;
    repeat (4) @(posedge core_clk);
    check({31'h0, osc_enable[S_EXT]}, 32'h1);
    rst_n   <= 1'b0;
    rpd     <= 1'b1;
    lf_req  <= 1'b0;
    ext_req <= 1'b0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    for (cnt = 0; cnt < 300; cnt++) begin
      @(posedge core_clk);
      if (core_rst_hold === 1'b0) break;
    end
    check(32'(cnt >= 145 && cnt <= 170), 32'h1);
    $display("test second reset done");
    conclude();
  end
endmodule
